// *** bdsi_core.sv ***
// Burst-of-four double rate SRAM interface, link and housekeeping logic
`timescale 1ns/100ps
module bdsi_core (
    input  wire logic                           clk_i,
    input  wire logic                           arst_n_i,
    input  wire logic                           k_clk_i,
    input  wire logic [bdsi_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic                           rw_i,
    input  wire logic                           load_strobe_n_i,
    input  wire logic [1:0]                     lane_write_mask_n_i,
    input  wire logic [bdsi_pkg::WORD_W-1:0]    d_i,
    input  wire logic                           pll_bypass_n_i,
    input  wire logic                           out_clk_p_i,
    input  wire logic                           out_clk_n_i,
    input  wire logic                           impedance_ref_pin_i,
    output logic      [bdsi_pkg::WORD_W-1:0]    q_rise_o,
    output logic      [bdsi_pkg::WORD_W-1:0]    q_fall_o,
    output logic                                q_oe_rise_o,
    output logic                                q_oe_fall_o,
    output logic      [1:0]                     returned_timing_pair_rise_o,
    output logic      [1:0]                     returned_timing_pair_fall_o,
    output logic                                pll_locked_o,
    output logic      [bdsi_pkg::IMP_W-1:0]     impedance_code_o,
    output logic                                impedance_update_o,
    output logic                                single_clock_o
);
    localparam int WW = bdsi_pkg::WORD_W;
    localparam int LW = bdsi_pkg::LINE_W;
    localparam int BW = bdsi_pkg::BYTE_W;

    bdsi_pkg::bdsi_k_t       k_q;
    bdsi_pkg::bdsi_k_t       k_d;
    bdsi_pkg::bdsi_neg_t     neg_q;
    bdsi_pkg::bdsi_c_t       c_q;
    bdsi_pkg::bdsi_c_t       c_d;
    bdsi_pkg::bdsi_wr_port_t wp;
    logic [1:0]              k_sync;     // {ready, pipeline on}
    logic [3:0]              c_sync;     // {strap p, strap n, ref, pipe on}
    logic [LW-1:0]           mem_rdata;
    logic [LW-1:0]           asm_data;
    logic [bdsi_pkg::EN_W-1:0] asm_en;
    logic [LW-1:0]           new_data;
    logic [bdsi_pkg::EN_W-1:0] new_en;
    logic [bdsi_pkg::ROW_W-1:0] new_row;
    logic                    new_v;
    logic [LW-1:0]           rd_line;
    logic [LW-1:0]           cur_line;
    logic [WW-1:0]           w0, w1, w2, w3;
    logic                    acc;
    logic                    acc_rd;
    logic                    acc_wr;

    // Word of a row at a burst position
    function automatic logic [WW-1:0] get_word(input logic [LW-1:0] line,
                                               input logic [1:0] lane);
        return line[lane*WW +: WW];
    endfunction

    // Place a word in a row lane
    function automatic logic [LW-1:0] put_word(input logic [LW-1:0] line,
                                               input logic [1:0] lane,
                                               input logic [WW-1:0] w);
        logic [LW-1:0] r;
        r = line;
        r[lane*WW +: WW] = w;
        return r;
    endfunction

    // Overlay enabled bytes of src onto base
    function automatic logic [LW-1:0] merge(input logic [LW-1:0] base,
                                            input logic [LW-1:0] src,
                                            input logic [7:0] en);
        logic [LW-1:0] r;
        r = base;
        for (int i = 0; i < bdsi_pkg::EN_W; i++) begin
            if (en[i]) begin
                r[i*BW +: BW] = src[i*BW +: BW];
            end
        end
        return r;
    endfunction

    // Level crossings into each domain
    bdsi_sync #(.W(2)) u_sync_k (
        .clk_i    (k_clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({c_q.locked, pll_bypass_n_i}),
        .q_o      (k_sync)
    );
    bdsi_sync #(.W(4)) u_sync_c (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({out_clk_p_i, out_clk_n_i, impedance_ref_pin_i,
                    pll_bypass_n_i}),
        .q_o      (c_sync)
    );

    // Array, read address straight from the pins on the accepting edge
    bdsi_mem u_mem (
        .clk_i     (k_clk_i),
        .wr_i      (wp),
        .rd_en_i   (acc_rd),
        .rd_row_i  (addr_i[bdsi_pkg::ADDR_W-1:2]),
        .rd_data_o (mem_rdata)
    );

    // Word and masks on the negative input clock rise
    always_ff @(negedge k_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            neg_q <= '0;
        end else begin
            neg_q <= {d_i, lane_write_mask_n_i};
        end
    end

    // Link side next state
    always_comb begin
        k_d = k_q;
        wp  = '0;
        acc    = !load_strobe_n_i && !k_q.busy && k_sync[1];
        acc_rd = acc && rw_i;
        acc_wr = acc && !rw_i;
        k_d.busy = acc;

        // Finishing burst takes its last word from the negative edge
        asm_data = put_word(k_q.wr_data, 2'(k_q.wr_cnt + 2'h3), neg_q.d);
        asm_en   = k_q.wr_en;
        asm_en[2*(2'(k_q.wr_cnt + 2'h3)) +: 2] = ~neg_q.mask_n;

        // Newest write data that the array may not yet hold
        new_v    = k_q.fin || k_q.pv;
        new_row  = k_q.fin ? k_q.wr_row : k_q.p_row;
        new_data = k_q.fin ? asm_data : k_q.p_data;
        new_en   = k_q.fin ? asm_en : k_q.p_en;
        rd_line  = mem_rdata;
        if (new_v && new_row == k_q.rd_row) begin
            rd_line = merge(mem_rdata, new_data, new_en);
        end
        cur_line = (k_q.rd_st == bdsi_pkg::RD_FIRST) ? rd_line : k_q.rd_data;

        // Burst order wraps in the aligned group
        w0 = get_word(cur_line, k_q.rd_cnt);
        w1 = get_word(cur_line, 2'(k_q.rd_cnt + 2'h1));
        w2 = get_word(cur_line, 2'(k_q.rd_cnt + 2'h2));
        w3 = get_word(cur_line, 2'(k_q.rd_cnt + 2'h3));

        // Output lanes float unless a word is due
        k_d.oe_rise = 1'b0;
        k_d.oe_fall = 1'b0;
        k_d.tail_v  = 1'b0;
        if (k_q.tail_v) begin
            k_d.q_rise  = k_q.tail_w;
            k_d.oe_rise = 1'b1;
        end
        case (k_q.rd_st)
            bdsi_pkg::RD_FIRST: begin
                k_d.rd_data = rd_line;
                k_d.rd_st   = bdsi_pkg::RD_SECOND;
                if (k_q.slow) begin
                    k_d.q_fall  = w0;
                    k_d.oe_fall = 1'b1;
                end else begin
                    k_d.q_rise  = w0;
                    k_d.q_fall  = w1;
                    k_d.oe_rise = 1'b1;
                    k_d.oe_fall = 1'b1;
                end
            end
            bdsi_pkg::RD_SECOND: begin
                k_d.rd_st   = bdsi_pkg::RD_IDLE;
                k_d.oe_rise = 1'b1;
                k_d.oe_fall = 1'b1;
                if (k_q.slow) begin
                    k_d.q_rise = w1;
                    k_d.q_fall = w2;
                    k_d.tail_v = 1'b1;
                    k_d.tail_w = w3;
                end else begin
                    k_d.q_rise = w2;
                    k_d.q_fall = w3;
                end
            end
            default: begin
                k_d.rd_st = bdsi_pkg::RD_IDLE;
            end
        endcase
        if (acc_rd) begin
            k_d.rd_st  = bdsi_pkg::RD_FIRST;
            k_d.rd_cnt = addr_i[1:0];
            k_d.rd_row = addr_i[bdsi_pkg::ADDR_W-1:2];
            k_d.slow   = k_sync[0];
        end

        // Write data collection
        k_d.fin = 1'b0;
        case (k_q.wr_st)
            bdsi_pkg::WR_FIRST: begin
                k_d.wr_data = put_word(k_q.wr_data, k_q.wr_cnt, d_i);
                k_d.wr_en[2*k_q.wr_cnt +: 2] = ~lane_write_mask_n_i;
                k_d.wr_st = bdsi_pkg::WR_SECOND;
            end
            bdsi_pkg::WR_SECOND: begin
                k_d.wr_data = put_word(put_word(k_q.wr_data,
                                   2'(k_q.wr_cnt + 2'h1), neg_q.d),
                                   2'(k_q.wr_cnt + 2'h2), d_i);
                k_d.wr_en[2*(2'(k_q.wr_cnt + 2'h1)) +: 2] = ~neg_q.mask_n;
                k_d.wr_en[2*(2'(k_q.wr_cnt + 2'h2)) +: 2] =
                    ~lane_write_mask_n_i;
                k_d.fin   = 1'b1;
                k_d.wr_st = bdsi_pkg::WR_IDLE;
            end
            default: begin
                k_d.wr_st = bdsi_pkg::WR_IDLE;
            end
        endcase
        if (acc_wr) begin
            if (k_q.pv) begin
                wp.we   = 1'b1;
                wp.be   = k_q.p_en;
                wp.row  = k_q.p_row;
                wp.data = k_q.p_data;
                k_d.pv  = 1'b0;
            end
            k_d.wr_st  = bdsi_pkg::WR_FIRST;
            k_d.wr_cnt = addr_i[1:0];
            k_d.wr_row = addr_i[bdsi_pkg::ADDR_W-1:2];
            k_d.wr_en  = '0;
        end
        if (k_q.fin) begin
            k_d.pv     = 1'b1;
            k_d.p_row  = k_q.wr_row;
            k_d.p_data = asm_data;
            k_d.p_en   = asm_en;
        end

        // Echo lanes follow the clock pair
        k_d.echo_rise = bdsi_pkg::ECHO_RISE;
        k_d.echo_fall = bdsi_pkg::ECHO_FALL;
    end

    // Link side register, outputs float from reset
    always_ff @(posedge k_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            k_q <= '0;
        end else begin
            k_q <= k_d;
        end
    end

    // System clock side: lock timer, retune, strap
    always_comb begin
        c_d = c_q;
        c_d.imp_upd = 1'b0;
        if (c_sync[0]) begin
            if (c_q.lock_cnt != bdsi_pkg::LOCK_W'(bdsi_pkg::LOCK_CYC)) begin
                c_d.lock_cnt = c_q.lock_cnt + 1'b1;
            end
            c_d.locked = (c_d.lock_cnt ==
                          bdsi_pkg::LOCK_W'(bdsi_pkg::LOCK_CYC));
        end else begin
            c_d.lock_cnt = '0;
            c_d.locked   = 1'b1;
        end
        c_d.imp_cnt = c_q.imp_cnt + 1'b1;
        if (c_q.imp_cnt == bdsi_pkg::RETUNE_W'(bdsi_pkg::RETUNE_CYC - 1)) begin
            c_d.imp_upd = 1'b1;
            if (c_sync[1] && c_q.imp_code != bdsi_pkg::IMP_MAX) begin
                c_d.imp_code = c_q.imp_code + 1'b1;
            end else if (!c_sync[1] && c_q.imp_code != '0) begin
                c_d.imp_code = c_q.imp_code - 1'b1;
            end
        end
        if (!c_q.strap_done &&
            c_q.imp_cnt == bdsi_pkg::RETUNE_W'(bdsi_pkg::STRAP_AT)) begin
            c_d.strap_done = 1'b1;
            c_d.single_clk = c_sync[3] && c_sync[2];
        end
    end

    // System clock side register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            c_q          <= '0;
            c_q.imp_code <= bdsi_pkg::IMP_RST;
        end else begin
            c_q <= c_d;
        end
    end

    // Outputs straight from flip-flops
    assign q_rise_o                    = k_q.q_rise;
    assign q_fall_o                    = k_q.q_fall;
    assign q_oe_rise_o                 = k_q.oe_rise;
    assign q_oe_fall_o                 = k_q.oe_fall;
    assign returned_timing_pair_rise_o = k_q.echo_rise;
    assign returned_timing_pair_fall_o = k_q.echo_fall;
    assign pll_locked_o                = c_q.locked;
    assign impedance_code_o            = c_q.imp_code;
    assign impedance_update_o          = c_q.imp_upd;
    assign single_clock_o              = c_q.single_clk;

    // Checks on the link side and the system clock side
    sequence wr_collect_s;
        k_q.wr_st == bdsi_pkg::WR_FIRST ##1
        k_q.wr_st == bdsi_pkg::WR_SECOND ##1 k_q.fin;
    endsequence
    sequence slow_out_s;
        (q_oe_fall_o && !q_oe_rise_o) ##1 (q_oe_rise_o && q_oe_fall_o)
        ##1 q_oe_rise_o;
    endsequence

    fast_read_lat_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        acc_rd && !k_sync[0] && !k_q.tail_v |=> ##1 q_oe_rise_o
        && q_oe_fall_o ##1 q_oe_rise_o && q_oe_fall_o)
        else $error("fast read burst not on both lanes for two cycles");
    slow_read_lat_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        acc_rd && k_sync[0] && !k_q.tail_v |=> ##1 slow_out_s)
        else $error("slow read burst lane order wrong");
    req_spacing_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        acc |=> !acc)
        else $error("request accepted on the rise after another");
    burst_load_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        acc_rd |=> k_q.rd_cnt == $past(addr_i[1:0])
        && k_q.rd_row == $past(addr_i[bdsi_pkg::ADDR_W-1:2]))
        else $error("read address not loaded into counter");
    burst_wrap_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        k_q.rd_st == bdsi_pkg::RD_SECOND && !k_q.slow |=> q_fall_o == $past(w3))
        else $error("last read word not from wrapped position");
    out_float_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        k_q.rd_st == bdsi_pkg::RD_IDLE && !k_q.tail_v
        |=> !q_oe_rise_o && !q_oe_fall_o)
        else $error("data outputs driven with no burst due");
    wr_collect_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        acc_wr |=> wr_collect_s ##1 k_q.pv)
        else $error("write words not collected and posted");
    post_commit_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        acc_wr && k_q.pv |-> wp.we && wp.row == k_q.p_row && wp.be == k_q.p_en)
        else $error("posted write not committed on next write");
    wr_idle_a: assert property (@(posedge k_clk_i) disable iff (!arst_n_i)
        k_q.wr_st == bdsi_pkg::WR_IDLE && !acc_wr
        |=> k_q.wr_st == bdsi_pkg::WR_IDLE && !k_q.fin)
        else $error("inputs acted on with no write loaded");
    retune_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        c_q.imp_upd |-> c_q.imp_cnt == '0 ##1 !c_q.imp_upd [*8])
        else $error("impedance retune period wrong");
    lock_time_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(c_q.locked) && c_sync[0]
        |-> c_q.lock_cnt == bdsi_pkg::LOCK_W'(bdsi_pkg::LOCK_CYC))
        else $error("lock flagged before settling time");
endmodule

// *** bdsi_pkg.sv ***
// Constants, state encodings and carrier structs of the burst SRAM interface
package bdsi_pkg;

    // Array and data path geometry
    localparam int ADDR_W = 20;
    localparam int ROW_W  = 18;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam int EN_W   = 8;
    localparam int LINE_W = 72;

    // Timing of the system clock domain
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int LOCK_TIME_US = 20;
    localparam int LOCK_CYC     = (LOCK_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int LOCK_W       = $clog2(LOCK_CYC + 1);
    localparam int RETUNE_CYC   = 1024;
    localparam int RETUNE_W     = $clog2(RETUNE_CYC);
    localparam int STRAP_AT     = 3;

    // Impedance code and echo lane patterns
    localparam int IMP_W = 4;
    localparam logic [IMP_W-1:0] IMP_RST   = 4'h8;
    localparam logic [IMP_W-1:0] IMP_MAX   = 4'hF;
    localparam logic [1:0]       ECHO_RISE = 2'h1;
    localparam logic [1:0]       ECHO_FALL = 2'h2;

    // Read sequencer, Gray coded
    typedef enum logic [1:0] {
        RD_IDLE   = 2'h0,
        RD_FIRST  = 2'h1,
        RD_SECOND = 2'h3
    } bdsi_rd_st_t;

    // Write data collector, Gray coded
    typedef enum logic [1:0] {
        WR_IDLE   = 2'h0,
        WR_FIRST  = 2'h1,
        WR_SECOND = 2'h3
    } bdsi_wr_st_t;

    // Word and masks caught on the negative input clock edge
    typedef struct packed {
        logic [WORD_W-1:0] d;
        logic [1:0]        mask_n;
    } bdsi_neg_t;

    // Array write port
    typedef struct packed {
        logic              we;
        logic [EN_W-1:0]   be;
        logic [ROW_W-1:0]  row;
        logic [LINE_W-1:0] data;
    } bdsi_wr_port_t;

    // Link side state
    typedef struct packed {
        bdsi_rd_st_t       rd_st;
        logic              busy;
        logic              slow;
        logic [1:0]        rd_cnt;
        logic [ROW_W-1:0]  rd_row;
        logic [LINE_W-1:0] rd_data;
        logic              tail_v;
        logic [WORD_W-1:0] tail_w;
        bdsi_wr_st_t       wr_st;
        logic              fin;
        logic [1:0]        wr_cnt;
        logic [ROW_W-1:0]  wr_row;
        logic [LINE_W-1:0] wr_data;
        logic [EN_W-1:0]   wr_en;
        logic              pv;
        logic [ROW_W-1:0]  p_row;
        logic [LINE_W-1:0] p_data;
        logic [EN_W-1:0]   p_en;
        logic [WORD_W-1:0] q_rise;
        logic [WORD_W-1:0] q_fall;
        logic              oe_rise;
        logic              oe_fall;
        logic [1:0]        echo_rise;
        logic [1:0]        echo_fall;
    } bdsi_k_t;

    // System clock side state
    typedef struct packed {
        logic [LOCK_W-1:0]   lock_cnt;
        logic                locked;
        logic [RETUNE_W-1:0] imp_cnt;
        logic                imp_upd;
        logic [IMP_W-1:0]    imp_code;
        logic                strap_done;
        logic                single_clk;
    } bdsi_c_t;

endpackage

// *** bdsi_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module bdsi_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// *** bdsi_mem.sv ***
// Four-way array: one 72-bit row per burst, nine-bit byte lanes
`timescale 1ns/100ps
module bdsi_mem (
    input  wire logic                           clk_i,
    input  wire bdsi_pkg::bdsi_wr_port_t        wr_i,
    input  wire logic                           rd_en_i,
    input  wire logic [bdsi_pkg::ROW_W-1:0]     rd_row_i,
    output logic      [bdsi_pkg::LINE_W-1:0]    rd_data_o
);
    localparam int BW = bdsi_pkg::BYTE_W;

    // One storage slice per byte lane, read data registered
    for (genvar g = 0; g < bdsi_pkg::EN_W; g++) begin : g_lane
        logic [BW-1:0] arr [2**bdsi_pkg::ROW_W];
        always_ff @(posedge clk_i) begin
            if (wr_i.we && wr_i.be[g]) begin
                arr[wr_i.row] <= wr_i.data[g*BW +: BW];
            end
            if (rd_en_i) begin
                rd_data_o[g*BW +: BW] <= arr[rd_row_i];
            end
        end
    end
endmodule

// *** bdsi_ctrl_model.sv ***
// Memory controller model: requests, write words and masks on the link
`timescale 1ns/100ps
module bdsi_ctrl_model (
    input  wire logic        k_clk_i,
    output logic      [19:0] addr_o,
    output logic             rw_o,
    output logic             ld_n_o,
    output logic      [1:0]  mask_n_o,
    output logic      [17:0] d_o
);
    // Idle, no request pending
    initial {addr_o, rw_o, ld_n_o, mask_n_o, d_o} = {20'h0, 4'hF, 18'h0};
    // Strobe low over n rises, then write words on four edges
    task automatic req(input logic rw, input logic [19:0] a,
            input logic [71:0] w, input logic [7:0] m, input int n);
        @(posedge k_clk_i);
        addr_o <= a;
        rw_o   <= rw;
        ld_n_o <= 1'b0;
        repeat (n) @(posedge k_clk_i);
        ld_n_o <= 1'b1;
        addr_o <= ~a;
        for (int i = 0; i < 4 && !rw; i++) begin
            if (i[0]) @(posedge k_clk_i);
            if (i == 2) @(negedge k_clk_i);
            d_o      <= w[18*i +: 18];
            mask_n_o <= m[2*i +: 2];
        end
        @(negedge k_clk_i);
        d_o      <= ~d_o;
        mask_n_o <= 2'h3;
    endtask
endmodule

// *** testbench.sv ***
// Bench: bursts, masks, posting, spacing and housekeeping
`timescale 1ns/100ps
module testbench;
    logic        clk_i = 1'b0, k_clk = 1'b0, arst_n = 1'b0, imp_ref = 1'b0;
    logic        rw, ld_n, oe_r, oe_f, lock, upd, one_clk;
    logic        bypass_n = 1'b0;
    logic [1:0]  mask_n, echo_r, echo_f;
    logic [19:0] addr;
    logic [17:0] d, q_r, q_f;
    logic [17:0] mem [logic [19:0]];
    logic [17:0] exp_q [$];
    logic [31:0] rng = 32'hF111;
    int          errors = 0, checks = 0, cyc = 0, n;
    bdsi_ctrl_model bdsi_ctrl_model_i (.k_clk_i(k_clk), .addr_o(addr),
        .rw_o(rw), .ld_n_o(ld_n), .mask_n_o(mask_n), .d_o(d));
    bdsi_core bdsi_core_i (.clk_i(clk_i), .arst_n_i(arst_n),
        .k_clk_i(k_clk), .addr_i(addr), .rw_i(rw), .load_strobe_n_i(ld_n),
        .lane_write_mask_n_i(mask_n), .d_i(d), .pll_bypass_n_i(bypass_n),
        .out_clk_p_i(1'b0), .out_clk_n_i(1'b0),
        .impedance_ref_pin_i(imp_ref), .q_rise_o(q_r), .q_fall_o(q_f),
        .q_oe_rise_o(oe_r), .q_oe_fall_o(oe_f),
        .returned_timing_pair_rise_o(echo_r),
        .returned_timing_pair_fall_o(echo_f), .pll_locked_o(lock),
        .impedance_code_o(), .impedance_update_o(upd),
        .single_clock_o(one_clk));
    // Two unrelated clocks; random comparator level
    initial forever #50 clk_i = ~clk_i;
    initial #17 forever #40 k_clk = ~k_clk;
    always @(negedge clk_i) imp_ref <= rng[3];
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Random burst written; reference array keeps unmasked bytes
    task automatic wr(input logic [19:0] a, input logic [7:0] m);
        logic [71:0] w;
        logic [19:0] wa;
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            w[18*i +: 18] = rng[17:0];
            wa = {a[19:2], a[1:0] + 2'(i)};
            if (!m[2*i]) mem[wa][8:0] = rng[8:0];
            if (!m[2*i+1]) mem[wa][17:9] = rng[17:9];
        end
        bdsi_ctrl_model_i.req(1'b0, a, w, m, 1);
    endtask
    // Read: four expected words queued, idle slot kept after it
    task automatic rd(input logic [19:0] a, input int k);
        for (int i = 0; i < 4; i++)
            exp_q.push_back(mem[{a[19:2], a[1:0] + 2'(i)}]);
        bdsi_ctrl_model_i.req(1'b1, a, 72'h0, 8'hFF, k);
        @(posedge k_clk);
    endtask
    // Every driven word takes the oldest note; none left means a stray word
    always @(posedge k_clk) begin
        #1;
        if (oe_r === 1'b1) cmp(q_r, exp_q.size() ? exp_q.pop_front() : ~q_r);
        if (oe_f === 1'b1) cmp(q_f, exp_q.size() ? exp_q.pop_front() : ~q_f);
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        arst_n = 1'b1;
        for (n = 0; n < 50 && lock !== 1'b1; n++) @(negedge clk_i);
        repeat (4) @(posedge k_clk);
        cmp(18'(lock), 18'h1);
        cmp(18'(one_clk), 18'h0);
        cmp(18'(echo_r), 18'(bdsi_pkg::ECHO_RISE));
        cmp(18'(echo_f), 18'(bdsi_pkg::ECHO_FALL));
        $display("test start done");
        wr(20'h00010, 8'h00);
        wr(20'h00022, 8'h00);
        rd(20'h00023, 1);
        rd(20'h00011, 1);
        $display("test bursts done");
        wr(20'h00011, 8'h9C);
        rd(20'h00012, 2);
        wr(20'h00030, 8'hFF);
        rd(20'h00010, 1);
        repeat (4) @(posedge k_clk);
        cmp(18'(exp_q.size()), 18'h0);
        $display("test masks done");
        @(negedge clk_i);
        bypass_n = 1'b1;
        repeat (4) @(negedge clk_i);
        for (n = 0; n < 300 && lock !== 1'b1; n++) @(negedge clk_i);
        repeat (4) @(posedge k_clk);
        cmp(18'(lock), 18'h1);
        rd(20'h00011, 1);
        rd(20'h00022, 2);
        repeat (4) @(posedge k_clk);
        cmp(18'(exp_q.size()), 18'h0);
        $display("test slow done");
        for (n = 0; n < 1100 && upd !== 1'b1; n++) @(negedge clk_i);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (upd !== 1'b1 && n < 1100);
        cmp(18'(n), 18'h400);
        $display("test retune done");
        wrap_up();
    end
endmodule
